// [logic/aivf_cfg.svh]
// Constants for the analog input value formatter
// Operation
// - Results are 16-bit two's complement, sign in bit 15, low four bits zero except in 7FFFh.
// - Above overdrive end output 7FFFh; below underdrive end output 8000h.
// - An invalid channel configuration makes the channel output 7FFFh.
// - Each channel has an averaging filter; after reset it is the 1000 ms setting.
// - Filter byte: bits 1:0 channel 0, bits 3:2 channel 1; 00/01/10 select 2/100/1000 ms.
// - After a runtime record write, output 7FFFh for 2 ms while applying.
// - Channel results appear at input image addresses 800 and 802.
`ifndef AIVF_CFG_SVH
`define AIVF_CFG_SVH
`define CLK_HZ          25000000
`define ADR_RSVD0       16'h0000
`define ADR_FILTER      16'h0001
`define ADR_CH0         16'h0320
`define ADR_CH1         16'h0322
`define FILTER_RESET    8'h10
`define FLT_CH0_LSB     0
`define FLT_CH1_LSB     2
`define CODE_POS_FULL   16'sh7FFF
`define CODE_NEG_FULL   16'sh8000
`define CODE_OVER_MAX   16'sh7EFF
`define CODE_UNDER_MIN  -16'sh08A4
`define APPLY_TIME_US   2000
`define APPLY_CYCLES    ((`APPLY_TIME_US * (`CLK_HZ / 1000000)))
`define SAMPLE_TIME_US  2000
`define SAMPLE_CYCLES   ((`SAMPLE_TIME_US * (`CLK_HZ / 1000000)))
`define AVG_LOG_100MS   6
`define AVG_LOG_1000MS  9
`endif

// [logic/aivf_pkg.sv]
// Types for the analog input value formatter
package aivf_pkg;
	typedef enum logic [1:0] {
		FILT_2MS    = 2'b00,
		FILT_100MS  = 2'b01,
		FILT_1000MS = 2'b10,
		FILT_BAD    = 2'b11
	} filter_e;
	typedef struct packed {
		logic        read;
		logic [15:0] addr;
	} rd_req_s;
	typedef struct packed {
		logic        write;
		logic [15:0] addr;
		logic [7:0]  data;
	} wr_req_s;
endpackage

// [logic/aivf_top.sv]
// Two-channel analog input value formatter
`timescale 1ns/1ns
`default_nettype none
`include "aivf_cfg.svh"
module aivf_top (
	// Clock and reset
	input  wire logic            CLK,
	input  wire logic            RESETN,
	// Converter samples, signed, scaled 27648 per 10 V
	input  wire logic signed [17:0] CH0_RAW,
	input  wire logic signed [17:0] CH1_RAW,
	// Parameter record write port
	input  wire aivf_pkg::wr_req_s  WR,
	// Input image read port
	input  wire aivf_pkg::rd_req_s  RD,
	output var  logic [15:0]        RD_DATA,
	output var  logic               RD_VALID,
	// Current channel words
	output var  logic [15:0]        CH0_WORD,
	output var  logic [15:0]        CH1_WORD,
	output var  logic               APPLY_BUSY
);
	import aivf_pkg::*;

	localparam int APPLY_N  = `APPLY_CYCLES;
	localparam int SAMPLE_N = `SAMPLE_CYCLES;

	logic [7:0]        filter_q;
	logic [7:0]        staged_q;
	logic [16:0]       apply_cnt_q;
	logic [16:0]       samp_cnt_q;
	logic              tick;
	logic signed [27:0] acc_q   [2];
	logic signed [17:0] raw     [2];
	logic signed [17:0] filt    [2];
	logic [15:0]       word    [2];
	logic              wr_filter;
	logic              wr_record;
	logic              rd_ch0;
	logic              rd_ch1;
	logic              applying;
	logic              dflt_staged_q;
	logic              dflt_q;

	assign raw[0] = CH0_RAW;
	assign raw[1] = CH1_RAW;

	//////////////////////////////////////////////////////////////////////
	// Bus decode
	// Byte 1 of the record holds the filter field, byte 0 is reserved
	assign wr_filter = WR.write && (WR.addr == `ADR_FILTER);
	// Either byte of the record restarts the apply window
	assign wr_record = WR.write && (WR.addr == `ADR_FILTER || WR.addr == `ADR_RSVD0);
	// channel words in the input image
	assign rd_ch0    = RD.read && (RD.addr == `ADR_CH0);
	assign rd_ch1    = RD.read && (RD.addr == `ADR_CH1);
	// window open while the counter runs
	assign applying  = (apply_cnt_q != '0);

	//////////////////////////////////////////////////////////////////////
	// filter byte write
	// Byte 1 writes stage its low four bits, upper bits cleared; only byte 1 holds settings
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			staged_q <= `FILTER_RESET;
		end else if (wr_filter) begin
			staged_q <= {4'h0, WR.data[3:0]};
		end
	end

	// 1000 ms filter holds until a staged filter byte is applied at the end of the window
	// The default record byte only sets a reserved bit, so a flag keeps it
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			dflt_staged_q <= 1'b1;
		end else if (wr_filter) begin
			dflt_staged_q <= 1'b0;
		end
	end

	// apply delay window
	// A record write inside the window starts it over
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			apply_cnt_q <= '0;
		end else if (wr_record) begin
			apply_cnt_q <= 17'(APPLY_N);
		end else if (applying) begin
			apply_cnt_q <= apply_cnt_q - 17'h0_0001;
		end
	end

	// reset default, take staged byte at end of window
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			filter_q <= `FILTER_RESET;
			dflt_q   <= 1'b1;
		end else if (apply_cnt_q == 17'h0_0001) begin
			filter_q <= staged_q;
			dflt_q   <= dflt_staged_q;
		end
	end

	// Sample tick, one per 2 ms conversion period
	// Filters move only on this tick, so their time constants are in periods
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			samp_cnt_q <= '0;
		end else if (samp_cnt_q == 17'(SAMPLE_N - 1)) begin
			samp_cnt_q <= '0;
		end else begin
			samp_cnt_q <= samp_cnt_q + 17'd1;
		end
	end
	assign tick = (samp_cnt_q == 17'(SAMPLE_N - 1));

	//////////////////////////////////////////////////////////////////////
	// Per-channel filter and format
	for (genvar c = 0; c < 2; c++) begin : g_ch
		filter_e            sel;
		logic signed [17:0] sat;
		logic               over;
		logic               under;

		// field of this channel, 1000 ms until a byte is applied
		assign sel = dflt_q ? FILT_1000MS : filter_e'(filter_q[2*c +: 2]);

		// exponential averaging filter
		// Shift 6 settles in about 128 ms, shift 9 in about one second
		// A changed setting keeps the old sum, so the first outputs drift
		always_ff @(posedge CLK or negedge RESETN) begin
			if (!RESETN) begin
				acc_q[c] <= '0;
			end else if (tick) begin
				unique case (sel)
					FILT_100MS: acc_q[c] <= acc_q[c] - (acc_q[c] >>> `AVG_LOG_100MS)
						+ 28'(raw[c]);
					FILT_1000MS: acc_q[c] <= acc_q[c] - (acc_q[c] >>> `AVG_LOG_1000MS)
						+ 28'(raw[c]);
					default: acc_q[c] <= acc_q[c];
				endcase
			end
		end

		// Averaged value, or raw sample when unfiltered
		always_comb begin
			unique case (sel)
				FILT_100MS:  filt[c] = 18'(acc_q[c] >>> `AVG_LOG_100MS);
				FILT_1000MS: filt[c] = 18'(acc_q[c] >>> `AVG_LOG_1000MS);
				default:     filt[c] = raw[c];
			endcase
		end

		assign sat = filt[c] & ~18'sh0_000F;

		// ends of the overdrive and underdrive ranges
		assign over  = (filt[c] > 18'(`CODE_OVER_MAX));
		assign under = (filt[c] < 18'(`CODE_UNDER_MIN));

		always_comb begin
			if (applying) begin
				word[c] = `CODE_POS_FULL;
			end else if (sel == FILT_BAD) begin
				word[c] = `CODE_POS_FULL;
			end else if (over) begin
				word[c] = `CODE_POS_FULL;
			end else if (under) begin
				word[c] = `CODE_NEG_FULL;
			end else begin
				word[c] = sat[15:0];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Registered channel words, full scale while in reset
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			CH0_WORD <= `CODE_POS_FULL;
			CH1_WORD <= `CODE_POS_FULL;
		end else begin
			CH0_WORD <= word[0];
			CH1_WORD <= word[1];
		end
	end

	// busy flag, in step with the forced words
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			APPLY_BUSY <= 1'b0;
		end else begin
			APPLY_BUSY <= applying;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Input image port

	// read strobe answered one cycle later
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			RD_VALID <= 1'b0;
		end else begin
			RD_VALID <= RD.read;
		end
	end

	// input image read decode, other addresses read zero
	// Same source as the channel words, so a read matches them
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			RD_DATA <= '0;
		end else if (rd_ch0) begin
			RD_DATA <= word[0];
		end else if (rd_ch1) begin
			RD_DATA <= word[1];
		end else begin
			RD_DATA <= '0;
		end
	end
endmodule
`default_nettype wire

// [tb/aivf_src.sv]
// Analog source model for both inputs
`timescale 1ns/1ns
`default_nettype none
module aivf_src (
	// Applied and converted values
	input  wire logic signed [17:0] V0,
	input  wire logic signed [17:0] V1,
	output logic signed [17:0]      RAW0,
	output logic signed [17:0]      RAW1
);
	// Converter follows voltages
	assign RAW0 = V0;
	assign RAW1 = V1;
endmodule
`default_nettype wire

// [tb/aivf_top_props.sv]
// Port checker for the formatter
`timescale 1ns/1ns
`default_nettype none
module aivf_top_props (
	input wire logic              CLK,
	input wire logic              RESETN,
	input wire aivf_pkg::wr_req_s WR,
	input wire aivf_pkg::rd_req_s RD,
	input wire logic [15:0]       RD_DATA,
	input wire logic              RD_VALID,
	input wire logic [15:0]       CH0_WORD,
	input wire logic              APPLY_BUSY
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	sequence s_busy; APPLY_BUSY [*8]; endsequence
	a_read_valid: assert property (RD.read |=> RD_VALID) else $error("no valid");
	a_valid_cause: assert property (RD_VALID |-> $past(RD.read)) else $error("stray");
	a_unmapped_zero: assert property (
		RD.read && RD.addr != 16'h0320 && RD.addr != 16'h0322 |=> RD_DATA == 16'h0000)
		else $error("unmapped data");
	a_low_bits: assert property (CH0_WORD != 16'h7FFF |-> CH0_WORD[3:0] == 4'h0)
		else $error("low bits set");
	a_busy_start: assert property (
		WR.write && WR.addr <= 16'h0001 |-> ##[1:2] APPLY_BUSY)
		else $error("no busy");
	a_busy_words: assert property (APPLY_BUSY |-> CH0_WORD == 16'h7FFF)
		else $error("word during apply");
	a_busy_hold: assert property ($rose(APPLY_BUSY) |-> s_busy) else $error("short");
	a_wr_ignored: assert property (
		WR.write && WR.addr > 16'h0001 && !APPLY_BUSY
		&& !($past(WR.write) && $past(WR.addr) <= 16'h0001)
		|=> !APPLY_BUSY) else $error("bad write taken");
endmodule
bind aivf_top aivf_top_props u_props (.CLK(CLK), .RESETN(RESETN), .WR(WR), .RD(RD),
	.RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .CH0_WORD(CH0_WORD), .APPLY_BUSY(APPLY_BUSY));
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the formatter
`timescale 1ns/1ns
`default_nettype none
`include "aivf_cfg.svh"
module testbench;
	import aivf_pkg::*;
	logic CLK = 0, RESETN = 0, RD_VALID, APPLY_BUSY;
	logic signed [17:0] v0 = 0, v1 = 0, CH0_RAW, CH1_RAW;
	wr_req_s WR = '0;
	rd_req_s RD = '0;
	logic [15:0] RD_DATA, CH0_WORD, CH1_WORD;
	int fail_count = 0, checks = 0;
	always #20 CLK = ~CLK;
	aivf_src u_aivf_src (.V0(v0), .V1(v1), .RAW0(CH0_RAW), .RAW1(CH1_RAW));
	aivf_top u_aivf_top (.CLK(CLK), .RESETN(RESETN), .CH0_RAW(CH0_RAW), .CH1_RAW(CH1_RAW),
		.WR(WR), .RD(RD), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .CH0_WORD(CH0_WORD),
		.CH1_WORD(CH1_WORD), .APPLY_BUSY(APPLY_BUSY));
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t %h %h", $time, seen, exp);
		end
	endtask
	task print_verdict;
		if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge CLK) WR <= '{1'b1, a, d};
		@(posedge CLK) WR <= '0;
		@(posedge CLK) #1;
	endtask
	task rd_word(input logic [15:0] a, input logic [15:0] exp);
		@(posedge CLK) RD <= '{1'b1, a};
		@(posedge CLK) RD <= '0;
		#1 chk({15'h0000, RD_VALID}, 16'h0001);
		chk(RD_DATA, exp);
	endtask
	// Power-on filter is the 1000 ms one, so a step does not pass at once
	task t_default;
		@(posedge CLK) v0 <= 18'sh0_3607;
		v1 <= 18'sh0_3607;
		repeat (4) @(posedge CLK);
		#1 chk(CH0_WORD, 16'h0000);
		chk(CH1_WORD, 16'h0000);
	endtask
	// Record write, apply window, saturation and reads
	task t_main;
		logic signed [17:0] vals [5];
		logic [15:0] exps [5];
		int n;
		vals = '{32511, 32512, -2212, -2213, 13831};
		exps = '{16'h7EF0, 16'h7FFF, 16'hF750, 16'h8000, 16'h3600};
		wr(16'h0005, 8'h00);
		chk({15'h0000, APPLY_BUSY}, 16'h0000);
		wr(16'h0001, 8'hFC);
		chk({15'h0000, APPLY_BUSY}, 16'h0001);
		chk(CH0_WORD, 16'h7FFF);
		n = 0;
		while (APPLY_BUSY && n < `APPLY_CYCLES + 10) begin
			@(posedge CLK) #1;
			n++;
		end
		chk({15'h0000, APPLY_BUSY}, 16'h0000);
		chk(16'(n), 16'(`APPLY_CYCLES));
		for (int i = 0; i < 5; i++) begin
			@(posedge CLK) v0 <= vals[i];
			repeat (4) @(posedge CLK);
			#1 chk(CH0_WORD, exps[i]);
			chk(CH1_WORD, 16'h7FFF);
		end
		rd_word(16'h0320, 16'h3600);
		rd_word(16'h0322, 16'h7FFF);
		rd_word(16'h0100, 16'h0000);
	endtask
	initial begin
		repeat (20) @(posedge CLK);
		#1 chk(CH0_WORD, 16'h7FFF);
		@(posedge CLK) RESETN <= 1'b1;
		t_default();
		t_main();
		print_verdict();
	end
	// Watchdog
	initial begin
		#2400000;
		fail_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
